//--- design/fpec_pkg.sv
// constants and types for the flash program and erase control block
// ============================================================
package fpec_pkg;

  // ============================================================
  // register offsets
  localparam logic [15:0] OFS_CTRL     = 16'h0760;
  localparam logic [15:0] OFS_ADR_LO   = 16'h0762;
  localparam logic [15:0] OFS_ADR_HI   = 16'h0764;
  localparam logic [15:0] OFS_KEY      = 16'h0766;
  localparam logic [15:0] OFS_INJ_CTL  = 16'h076c;
  localparam logic [15:0] OFS_INJ_PTR  = 16'h076e;
  localparam logic [15:0] OFS_EADR_LO  = 16'h0770;
  localparam logic [15:0] OFS_EADR_HI  = 16'h0772;
  localparam logic [15:0] OFS_STAT_LO  = 16'h0774;
  localparam logic [15:0] OFS_STAT_HI  = 16'h0776;

  // ============================================================
  // control and status register fields
  localparam int BIT_WR    = 15;
  localparam int BIT_EN    = 14;
  localparam int BIT_WERR  = 13;
  localparam int BIT_SIDL  = 12;
  localparam int BIT_SWAP  = 11;
  localparam int BIT_P2    = 10;
  localparam int BIT_ARM   = 0;
  localparam int DED_IN_BIT  = 8;
  localparam int DED_OUT_BIT = 9;

  // ============================================================
  // operation codes
  localparam logic [3:0] OP_DWORD = 4'h1;
  localparam logic [3:0] OP_ROW   = 4'h2;
  localparam logic [3:0] OP_PAGE  = 4'h3;
  localparam logic [3:0] OP_INACT = 4'h4;
  localparam logic [3:0] OP_BOOT  = 4'h8;
  localparam logic [3:0] OP_CHIP  = 4'he;

  // ============================================================
  // unlock values and fault injection span
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam int         INJ_BITS   = 137;

  // ============================================================
  // operation durations in clock cycles
  localparam int TMR_W       = 20;
  localparam int T_DWORD_CYC = 2000;
  localparam int T_ROW_CYC   = 20000;
  localparam int T_PAGE_CYC  = 40000;
  localparam int T_CHIP_CYC  = 80000;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_HALF,
    KEY_OPEN
  } fpec_key_t;

endpackage

//--- design/fpec_timer.sv
// self-timed operation counter
`timescale 1ns/100ps
module fpec_timer
  import fpec_pkg::*;
#(
  parameter int W = TMR_W
)(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         abort,
  output logic              busy
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } fpec_tmr_t;

  fpec_tmr_t q;
  fpec_tmr_t d;

  // ============================================================
  // countdown; abort beats load so a fault ends the run at once
  always_comb
  begin
    d = q;
    if (abort)
      d.cnt = '0;
    else if (load)
      d.cnt = load_val;
    else if (q.cnt != '0)
      d.cnt = q.cnt - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end

  assign busy = (q.cnt != '0);

endmodule

//--- design/fpec_core.sv
// flash program and erase control with ecc injection registers
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
module fpec_core
  import fpec_pkg::*;
#(
  parameter int DWORD_CYC = T_DWORD_CYC,
  parameter int ROW_CYC   = T_ROW_CYC,
  parameter int PAGE_CYC  = T_PAGE_CYC,
  parameter int CHIP_CYC  = T_CHIP_CYC
)(
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                por_n,
  input  wire logic [15:0]         reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_we,
  input  wire logic                reg_re,
  output logic      [15:0]         reg_rdata,
  input  wire logic                dual_partition,
  input  wire logic                swap_done_status,
  input  wire logic                second_partition_active,
  input  wire logic                idle_mode,
  input  wire logic                flash_fault,
  output logic                     op_start,
  output logic                     op_busy,
  output logic      [3:0]          op_code,
  output logic      [23:0]         op_addr,
  output logic                     flash_power_off,
  output logic                     flash_standby,
  input  wire logic [23:0]         flash_access_addr,
  input  wire logic                ecc_valid,
  input  wire logic [7:0]          read_single_parity,
  input  wire logic [7:0]          computed_single_parity,
  input  wire logic                read_double_parity,
  input  wire logic                computed_double_parity,
  output logic                     inject_hit,
  output logic      [INJ_BITS-1:0] inject_mask
);

  typedef struct packed {
    fpec_key_t   key;
    logic        wr;
    logic        pgm_en;
    logic        werr;
    logic        start;
    logic [3:0]  run_op;
    logic [23:0] run_addr;
    logic        sidl;
    logic [3:0]  op;
    logic [15:0] adr_lo;
    logic [7:0]  adr_hi;
    logic        inj_arm;
    logic [7:0]  ptr1;
    logic [7:0]  ptr2;
    logic [15:0] eadr_lo;
    logic [7:0]  eadr_hi;
    logic [7:0]  sec_in;
    logic [7:0]  sec_out;
    logic [7:0]  synd;
    logic        ded_in;
    logic        ded_out;
    logic [15:0] rdata;
  } fpec_state_t;

  fpec_state_t q;
  fpec_state_t d;
  fpec_state_t keep;

  logic             t_busy;
  logic [TMR_W-1:0] t_len;
  logic             wr_ctrl;
  logic             set_try;
  logic [3:0]       new_op;
  logic             op_ok;
  logic             swap_rd;
  logic             p2_rd;

  // ============================================================
  // operation decode
  // unimplemented codes
  function automatic logic op_known(input logic [3:0] c, input logic dual);
    logic ok;
    ok = 1'b0;
    unique case (c)
      OP_DWORD, OP_ROW, OP_PAGE: ok = 1'b1;
      OP_CHIP:  ok = 1'b1;
      OP_BOOT:  ok = 1'b1;
      OP_INACT: ok = dual;
      default:  ok = 1'b0;
    endcase
    return ok;
  endfunction

  // run length picked from the launched code
  always_comb
  begin
    unique case (q.run_op)
      OP_DWORD: t_len = TMR_W'(DWORD_CYC);
      OP_BOOT:  t_len = TMR_W'(DWORD_CYC);
      OP_ROW:   t_len = TMR_W'(ROW_CYC);
      OP_PAGE:  t_len = TMR_W'(PAGE_CYC);
      default:  t_len = TMR_W'(CHIP_CYC);
    endcase
  end

  // ============================================================
  // partition status reads
  // swap status
  assign swap_rd = dual_partition & swap_done_status;
  assign p2_rd   = dual_partition & second_partition_active;

  assign wr_ctrl = reg_we && (reg_addr == OFS_CTRL);
  assign set_try = wr_ctrl && reg_wdata[BIT_WR];
  // the code is locked while a run is live, so decode what will stand
  assign new_op  = q.wr ? q.op : reg_wdata[3:0];
  assign op_ok   = op_known(new_op, dual_partition);

  // ============================================================
  // next state
  always_comb
  begin
    d = q;
    d.start = 1'b0;
    d.rdata = '0;

    // read mux, data stands only in the cycle after the strobe
    if (reg_re)
    begin
      unique case (reg_addr)
        OFS_CTRL:
        begin
          d.rdata[BIT_WR]   = q.wr;
          d.rdata[BIT_EN]   = q.pgm_en;
          d.rdata[BIT_WERR] = q.werr;
          d.rdata[BIT_SIDL] = q.sidl;
          d.rdata[BIT_SWAP] = swap_rd;
          d.rdata[BIT_P2]   = p2_rd;
          d.rdata[3:0]      = q.op;
        end
        OFS_ADR_LO:  d.rdata = q.adr_lo;
        OFS_ADR_HI:  d.rdata = {8'h00, q.adr_hi};
        OFS_KEY:     d.rdata = 16'h0000;
        OFS_INJ_CTL: d.rdata[BIT_ARM] = q.inj_arm;
        OFS_INJ_PTR: d.rdata = {q.ptr2, q.ptr1};
        OFS_EADR_LO: d.rdata = q.eadr_lo;
        OFS_EADR_HI: d.rdata = {8'h00, q.eadr_hi};
        OFS_STAT_LO: d.rdata = {q.sec_out, q.sec_in};
        OFS_STAT_HI:
        begin
          d.rdata[7:0]         = q.synd;
          d.rdata[DED_IN_BIT]  = q.ded_in;
          d.rdata[DED_OUT_BIT] = q.ded_out;
        end
        default:     d.rdata = '0;
      endcase
    end

    // unlock sequencer; any other write breaks the pair
    if (reg_we)
    begin
      if (reg_addr == OFS_KEY)
      begin
        unique case (q.key)
          KEY_IDLE: d.key = (reg_wdata[7:0] == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
          KEY_HALF:
          begin
            if (reg_wdata[7:0] == KEY_SECOND)
              d.key = KEY_OPEN;
            else if (reg_wdata[7:0] == KEY_FIRST)
              d.key = KEY_HALF;
            else
              d.key = KEY_IDLE;
          end
          KEY_OPEN: d.key = (reg_wdata[7:0] == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        endcase
      end
      else
        d.key = KEY_IDLE;
    end

    // control register: plain fields first
    if (wr_ctrl)
    begin
      d.pgm_en = reg_wdata[BIT_EN];
      d.werr = reg_wdata[BIT_WERR];
      d.sidl = reg_wdata[BIT_SIDL];
      if (!q.wr)
        d.op = reg_wdata[3:0];
    end

    // start attempts; zero in the start bit is simply ignored
    // settable only
    if (set_try)
    begin
      if (!q.wr && q.key == KEY_OPEN && reg_wdata[BIT_EN] && op_ok)
      begin
        d.wr      = 1'b1;
        d.start   = 1'b1;
        d.run_op  = new_op;
        d.run_addr = (new_op == OP_CHIP) ? 24'h000000 : {q.adr_hi, q.adr_lo};
      end
      else
      begin
        d.werr = 1'b1;
      end
    end

    // address and injection registers
    if (reg_we)
    begin
      unique case (reg_addr)
        OFS_ADR_LO:  d.adr_lo = reg_wdata;
        OFS_ADR_HI:  d.adr_hi = reg_wdata[7:0];
        OFS_INJ_CTL:
        begin
          // arming needs the unlock pair too, disarming never does
          if (!reg_wdata[BIT_ARM])
            d.inj_arm = 1'b0;
          else if (q.key == KEY_OPEN)
            d.inj_arm = 1'b1;
        end
        OFS_INJ_PTR:
        begin
          d.ptr1 = reg_wdata[7:0];
          d.ptr2 = reg_wdata[15:8];
        end
        OFS_EADR_LO: d.eadr_lo = reg_wdata;
        OFS_EADR_HI: d.eadr_hi = reg_wdata[7:0];
        OFS_STAT_LO:
        begin
          d.sec_in  = reg_wdata[7:0];
          d.sec_out = reg_wdata[15:8];
        end
        OFS_STAT_HI:
        begin
          d.synd    = reg_wdata[7:0];
          d.ded_in  = reg_wdata[DED_IN_BIT];
          d.ded_out = reg_wdata[DED_OUT_BIT];
        end
        default: d.inj_arm = d.inj_arm;
      endcase
    end

    // hardware capture of ecc read status wins over a software write
    if (ecc_valid)
    begin
      d.sec_in  = read_single_parity;
      d.sec_out = computed_single_parity;
      d.synd    = read_single_parity ^ computed_single_parity;
      d.ded_in  = read_double_parity;
      d.ded_out = computed_double_parity;
    end

    // completion and termination; placed last so hardware set wins
    if (q.wr && !q.start)
    begin
      if (flash_fault)
      begin
        d.wr   = 1'b0;
        d.werr = 1'b1;
      end
      else if (!t_busy)
      begin
        d.wr = 1'b0;
      end
    end
  end

  // ============================================================
  // values carried through a system reset
  always_comb
  begin
    keep = '0;
    keep.wr       = q.wr;
    keep.pgm_en   = q.pgm_en;
    keep.werr     = q.werr;
    // pulse already went out and the timer took it; holding it would stretch it
    keep.start    = 1'b0;
    keep.run_op   = q.run_op;
    keep.run_addr = q.run_addr;
  end

  // a system reset does not abort a run in flight
  always_ff @(posedge clk)
  begin
    if (!por_n)
      q <= '0;
    else if (!nrst)
      q <= keep;
    else
      q <= d;
  end

  // ============================================================
  // operation timer, kept alive across system reset
  fpec_timer #(
    .W (TMR_W)
  ) u_timer (
    .clk      (clk),
    .nrst     (por_n),
    .load     (q.start),
    .load_val (t_len),
    .abort    (flash_fault & q.wr & ~q.start),
    .busy     (t_busy)
  );

  // ============================================================
  // outputs to the flash array
  assign reg_rdata = q.rdata;
  assign op_start  = q.start;
  assign op_busy   = q.wr;
  assign op_code   = q.run_op;
  assign op_addr   = q.run_addr;

  assign flash_power_off = idle_mode & q.sidl;
  assign flash_standby   = idle_mode & ~q.sidl;

  // ============================================================
  // fault injection decode, pointers past the top never match
  assign inject_hit = q.inj_arm && (flash_access_addr == {q.eadr_hi, q.eadr_lo});

  for (genvar i = 0; i < INJ_BITS; i++)
  begin : g_inj
    assign inject_mask[i] = inject_hit && ((q.ptr1 == 8'(i)) || (q.ptr2 == 8'(i)));
  end

endmodule

//--- sim/fpec_checker.sv
// assertion checker for the flash program and erase control block
`timescale 1ns/100ps
module fpec_checker
  import fpec_pkg::*;
#(
  parameter int CHIP_CYC = T_CHIP_CYC
)(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        por_n,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_we,
  input wire logic        reg_re,
  input wire logic [15:0] reg_rdata,
  input wire logic        idle_mode,
  input wire logic        flash_fault,
  input wire logic        op_start,
  input wire logic        op_busy,
  input wire logic [3:0]  op_code,
  input wire logic [23:0] op_addr,
  input wire logic        flash_power_off,
  input wire logic        flash_standby
);
  // ============================================================
  // shadow of unlock state, idle option and busy length
  logic [1:0]  key_q;
  logic        sidl_q;
  logic [31:0] cnt_q;
  wire go    = reg_we && nrst && reg_addr == OFS_CTRL && reg_wdata[15];
  wire legal = reg_wdata[3:0] inside {OP_DWORD, OP_ROW, OP_PAGE, OP_BOOT, OP_CHIP};

  // any non-key write drops the unlock, as the hardware does
  always_ff @(posedge clk)
  begin
    if (!por_n || !nrst)
    begin
      key_q  <= 2'h0;
      sidl_q <= 1'b0;
    end
    else if (reg_we)
    begin
      if (reg_addr != OFS_KEY)
        key_q <= 2'h0;
      else if (reg_wdata[7:0] == KEY_FIRST)
        key_q <= 2'h1;
      else
        key_q <= (key_q == 2'h1 && reg_wdata[7:0] == KEY_SECOND) ? 2'h2 : 2'h0;
      if (reg_addr == OFS_CTRL)
        sidl_q <= reg_wdata[12];
    end
    cnt_q <= op_busy ? cnt_q + 32'h1 : 32'h0;
  end

  // ============================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!por_n);

  key_blank_a: assert property (reg_re && reg_addr == OFS_KEY |=> reg_rdata == 16'h0)
    else $error("key register read back nonzero");
  start_lock_a: assert property (go && key_q != 2'h2 |=> !op_start)
    else $error("start taken without unlock");
  enable_gate_a: assert property (go && !reg_wdata[14] |=> !op_start)
    else $error("start taken with enable low");
  bad_code_a: assert property (go && !legal && reg_wdata[3:0] != OP_INACT |=> !op_start)
    else $error("unimplemented code started");
  start_ok_a: assert property (go && reg_wdata[14] && key_q == 2'h2 && legal && !op_busy
    |=> op_start && op_code == $past(reg_wdata[3:0]))
    else $error("valid start not launched");
  pulse_once_a: assert property (op_start |=> !op_start)
    else $error("start pulse longer than one cycle");
  start_busy_a: assert property (op_start |-> op_busy)
    else $error("start without busy");
  busy_limit_a: assert property (op_busy |-> cnt_q <= CHIP_CYC + 4)
    else $error("busy never cleared");
  chip_addr_a: assert property (op_start && op_code == OP_CHIP |-> op_addr == 24'h0)
    else $error("chip erase carries an address");
  fault_stop_a: assert property (op_busy && flash_fault && !op_start |=> !op_busy)
    else $error("fault did not end operation");
  launch_hold_a: assert property (op_start ##1 !flash_fault |=> op_busy)
    else $error("fault in launch cycle ended operation");
  idle_power_a: assert property (flash_power_off == (idle_mode && sidl_q))
    else $error("power off output wrong");
  idle_standby_a: assert property (flash_standby == (idle_mode && !sidl_q))
    else $error("standby output wrong");

  cover property (op_start && op_code == OP_CHIP);
  cover property (op_busy && flash_fault);
  cover property (go && key_q != 2'h2);
endmodule

bind fpec_core fpec_checker #(.CHIP_CYC(CHIP_CYC)) u_chk (.clk, .nrst, .por_n, .reg_addr,
  .reg_wdata, .reg_we, .reg_re, .reg_rdata, .idle_mode, .flash_fault, .op_start, .op_busy,
  .op_code, .op_addr, .flash_power_off, .flash_standby);

//--- sim/test_flash_program_erase_control.sv
// self-checking bench for the flash program and erase control block
`timescale 1ns/100ps
module test_flash_program_erase_control
  import fpec_pkg::*;
;
  logic                clk, nrst, por_n, we, re, dual, swap, p2, idle, fault, ev, rdp, cdp;
  logic                st, op_start, op_busy, pwr_off, stby, hit;
  logic [15:0]         addr, wdata, rdata, rv;
  logic [23:0]         acc, op_addr;
  logic [7:0]          rsp, csp;
  logic [3:0]          op_code;
  logic [INJ_BITS-1:0] mask;
  logic [3:0]          codes [5] = '{OP_DWORD, OP_ROW, OP_PAGE, OP_BOOT, OP_CHIP};
  int                  bad_count, samples_checked, cyc;

  // short durations keep the run brief
  fpec_core #(.DWORD_CYC(5), .ROW_CYC(8), .PAGE_CYC(10), .CHIP_CYC(12)) u_dut (
    .clk(clk), .nrst(nrst), .por_n(por_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_we(we), .reg_re(re), .reg_rdata(rdata), .dual_partition(dual),
    .swap_done_status(swap), .second_partition_active(p2), .idle_mode(idle),
    .flash_fault(fault), .op_start(op_start), .op_busy(op_busy), .op_code(op_code),
    .op_addr(op_addr), .flash_power_off(pwr_off), .flash_standby(stby),
    .flash_access_addr(acc), .ecc_valid(ev), .read_single_parity(rsp),
    .computed_single_parity(csp), .read_double_parity(rdp), .computed_double_parity(cdp),
    .inject_hit(hit), .inject_mask(mask));

  // ============================================================
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      results();
    end
  end

  // ============================================================
  // shared tasks
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // nonblocking drives after the rising edge keep strobes clear of it; we stands one cycle, then one idle cycle follows
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    #1 st = op_start;
    @(posedge clk);
  endtask

  task automatic rd(input logic [15:0] a);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 rv = rdata;
    @(posedge clk);
  endtask

  task automatic unlock();
    wr(OFS_KEY, 16'h0055);
    wr(OFS_KEY, 16'h00aa);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 40 && op_busy !== 1'b0; i++)
      @(posedge clk);
    chk("busy", 24'h0, op_busy);
  endtask

  // ============================================================
  // scenarios
  task automatic t_reset();
    rd(OFS_CTRL);
    chk("ctrl_rst", 24'h0, rv);
    unlock();
    rd(OFS_KEY);
    chk("key", 24'h0, rv);
    rd(16'h0768);
    chk("hole", 24'h0, rv);
  endtask

  task automatic t_launch(input logic [3:0] c, input logic [23:0] ea);
    unlock();
    wr(OFS_CTRL, {12'hc00, c});
    chk("start", 24'h1, st);
    chk("code", {20'h0, c}, op_code);
    chk("addr", ea, op_addr);
    wr(OFS_CTRL, {12'h400, c});
    chk("hold", 24'h1, op_busy);
    rd(OFS_CTRL);
    chk("run", 24'h1, rv[15]);
    wait_idle();
    rd(OFS_CTRL);
    chk("done", {8'h0, 12'h400, c}, rv);
  endtask

  // mode 1 proper pair, 2 pair split by another write
  task automatic bad(input logic [15:0] cw, input int mode);
    wr(OFS_CTRL, 16'h0);
    if (mode != 0)
      wr(OFS_KEY, 16'h0055);
    if (mode == 2)
      wr(OFS_ADR_LO, 16'h3456);
    if (mode != 0)
      wr(OFS_KEY, 16'h00aa);
    wr(OFS_CTRL, cw);
    chk("refused", 24'h0, st);
    rd(OFS_CTRL);
    chk("err", {21'h0, 1'b0, cw[14], 1'b1}, rv[15:13]);
  endtask

  task automatic t_fault_reset();
    unlock();
    wr(OFS_CTRL, 16'hc002);
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    #1 chk("term", 24'h0, op_busy);
    rd(OFS_CTRL);
    chk("term_err", 24'h3, rv[15:13]);
    unlock();
    wr(OFS_CTRL, 16'hc00e);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chk("keep", 24'h1, op_busy);
    wait_idle();
    rd(OFS_CTRL);
    chk("kept", 24'h2, rv[15:13]);
  endtask

  task automatic t_status_idle();
    swap <= 1'b1;
    p2   <= 1'b1;
    rd(OFS_CTRL);
    chk("single", 24'h0, rv[11:10]);
    dual <= 1'b1;
    rd(OFS_CTRL);
    chk("dual", 24'h3, rv[11:10]);
    swap <= 1'b0;
    rd(OFS_CTRL);
    chk("await", 24'h1, rv[11:10]);
    wr(OFS_CTRL, 16'h1000);
    idle <= 1'b1;
    @(posedge clk);
    #1 chk("off", 24'h1, {stby, pwr_off});
    wr(OFS_CTRL, 16'h0);
    #1 chk("stby", 24'h2, {stby, pwr_off});
  endtask

  task automatic t_ecc();
    wr(OFS_EADR_LO, 16'h3456);
    wr(OFS_EADR_HI, 16'h0012);
    wr(OFS_INJ_PTR, 16'h8988);
    wr(OFS_INJ_CTL, 16'h0001);
    rd(OFS_INJ_CTL);
    chk("arm_lock", 24'h0, rv);
    unlock();
    wr(OFS_INJ_CTL, 16'h0001);
    acc <= 24'h123456;
    @(posedge clk);
    #1 chk("m136", 24'h1, hit && mask === {1'b1, 136'h0});
    wr(OFS_INJ_PTR, 16'h0100);
    chk("m01", 24'h1, mask === 137'h3);
    acc <= 24'h123457;
    @(posedge clk);
    #1 chk("miss", 24'h1, !hit && mask === 137'h0);
    rsp <= 8'h5a;
    csp <= 8'h1a;
    rdp <= 1'b1;
    ev  <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    rd(OFS_STAT_LO);
    chk("sec", 24'h1a5a, rv);
    rd(OFS_STAT_HI);
    chk("synd", 24'h0140, rv);
    csp <= 8'h5a;
    rdp <= 1'b0;
    cdp <= 1'b1;
    ev  <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    rd(OFS_STAT_HI);
    chk("synd0", 24'h0200, rv);
  endtask

  // ============================================================
  // main sequence
  initial
  begin
    {we, re, dual, swap, p2, idle, fault, ev, rdp, cdp} = 10'h0;
    {addr, wdata, acc, rsp, csp} = 72'h0;
    {nrst, por_n} = 2'h0;
    bad_count = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    nrst  <= 1'b1;
    por_n <= 1'b1;
    @(posedge clk);
    t_reset();
    wr(OFS_ADR_HI, 16'h0012);
    wr(OFS_ADR_LO, 16'h3456);
    foreach (codes[i])
      t_launch(codes[i], codes[i] == OP_CHIP ? 24'h0 : 24'h123456);
    bad(16'hc001, 0);
    bad(16'hc001, 2);
    bad(16'h8001, 1);
    bad(16'hc005, 1);
    bad(16'hc004, 1);
    dual <= 1'b1;
    t_launch(OP_INACT, 24'h123456);
    dual <= 1'b0;
    t_fault_reset();
    t_status_idle();
    t_ecc();
    results();
  end
endmodule
